// *** verilog/wdt_lvr_pkg.sv ***
// Constants shared by the watchdog and low-voltage reset supervisor
package wdt_uv_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_CLKMODE     = 8'h04;
  localparam logic [7:0]  OFF_STATUS      = 8'h08;
  localparam logic [7:0]  OFF_WDT_COUNT   = 8'h0C;
  // Control register field positions
  localparam int          CTRL_SEL_LSB    = 0;
  localparam int          CTRL_UV_DIS     = 2;
  localparam int          CTRL_WDT_EN     = 3;
  // Clock mode register field positions
  localparam int          CLK_RC_EN       = 0;
  // Status register field positions
  localparam int          ST_WDT_RUN      = 0;
  localparam int          ST_UV_ACT       = 1;
  localparam int          ST_CPU_RUN      = 2;
  // Reset values
  localparam logic        RST_WDT_EN      = 1'b1;
  localparam logic        RST_RC_EN       = 1'b1;
  localparam logic        RST_UV_DIS      = 1'b0;
  localparam logic [1:0]  RST_WDT_SEL     = 2'h0;
  // Watchdog periods in low RC oscillator cycles
  localparam logic [18:0] WDT_PER_00      = 19'h0_2000;
  localparam logic [18:0] WDT_PER_01      = 19'h0_4000;
  localparam logic [18:0] WDT_PER_10      = 19'h1_0000;
  localparam logic [18:0] WDT_PER_11      = 19'h4_0000;
  // Boot and wake delays in low RC oscillator cycles
  localparam logic [11:0] BOOT_SLOW_CYC   = 12'h0BB8;
  localparam logic [11:0] FAST_CYC        = 12'h002D;
  localparam logic [11:0] NORMAL_WAKE_CYC = 12'h0BB8;
  // Low-voltage reset threshold codes, 4.0V down to 1.8V
  localparam logic [2:0]  UV_4V0          = 3'h0;
  localparam logic [2:0]  UV_1V8          = 3'h7;
  // Supervisor states, one-hot
  typedef enum logic [3:0] {
    S_BOOT = 4'h1,
    S_RUN  = 4'h2,
    S_HALT = 4'h4,
    S_WAKE = 4'h8
  } sup_state_t;
endpackage

// *** verilog/sync2.sv ***
// Two flip-flop synchroniser for asynchronous input pins
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  // First stage feeds only the second stage
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.s2;
endmodule
`default_nettype wire

// *** verilog/wdt_lvr_supervisor.sv ***
// Watchdog timer, low-voltage reset gating and boot/wake delay with AHB-Lite registers
// Functional notes
// - Watchdog runs from reset without software
// - Calibration routine outside boot turns watchdog off until re-enabled
// - No counting while low RC oscillator disabled
// - Select 00/01/10/11 gives 8192/16384/65536/262144
// - Threshold level fixed at build time
// - Threshold active only after power-on completes
// - Control bit 2 set disables low-voltage reset
// - Low-voltage reset inactive in both halt modes
// - Fast wake-up waits 45 low RC cycles
// - Boot delay about 3000 slow, 45 fast
`timescale 1ns/1ns
`default_nettype none
module wdt_uv_supervisor
  import wdt_uv_pkg::*;
#(
  parameter logic [2:0]  UV_LEVEL    = UV_1V8,
  parameter logic        BOOT_SLOW   = 1'b1,
  parameter logic [18:0] WDT_PER0    = WDT_PER_00,
  parameter logic [18:0] WDT_PER1    = WDT_PER_01,
  parameter logic [18:0] WDT_PER2    = WDT_PER_10,
  parameter logic [18:0] WDT_PER3    = WDT_PER_11,
  parameter logic [11:0] WAKE_NORMAL = NORMAL_WAKE_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        low_speed_rc_osc,
  input  wire logic        low_voltage_detect,
  input  wire logic        wdt_clear,
  input  wire logic        clock_calibration_routine,
  input  wire logic        standby_halt_req,
  input  wire logic        powerdown_halt_req,
  input  wire logic        wake_event,
  input  wire logic        fast_wake_sel,
  output logic             wdt_reset,
  output logic             low_voltage_reset,
  output logic [2:0]       uv_threshold_sel,
  output logic             cpu_run
);
  // Parameter sanity
  initial begin
    if (WDT_PER0 == 19'h0_0000 || WDT_PER1 == 19'h0_0000 || WDT_PER2 == 19'h0_0000 || WDT_PER3 == 19'h0_0000)
      $error("watchdog period must be nonzero");
    if (WAKE_NORMAL == 12'h000)
      $error("wake delay must be nonzero");
  end

  typedef struct packed {
    sup_state_t  state;
    logic        wdt_en;
    logic        rc_en;
    logic        uv_dis;
    logic [1:0]  wdt_sel;
    logic [18:0] wdt_cnt;
    logic [11:0] dly_cnt;
    logic        fast_wake;
    logic        rc_prev;
    logic        wdt_rst;
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
  } sup_t;

  sup_t        st_reg;
  sup_t        st_next;
  logic [1:0]  pins_s;
  logic        rc_s;
  logic        lv_s;
  logic        tick;
  logic        aphase;
  logic        uv_active;
  logic [18:0] period;
  logic [11:0] wake_target;
  logic [11:0] boot_target;

  // Oscillator and comparator come from outside the clock domain
  sync2 #(.W(2)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    ({low_voltage_detect, low_speed_rc_osc}),
    .dout   (pins_s)
  );
  assign rc_s = pins_s[0];
  assign lv_s = pins_s[1];

  // One tick per low RC rising edge, gated by the oscillator enable
  assign tick = rc_s & ~st_reg.rc_prev & st_reg.rc_en;

  // Period lookup
  always_comb begin
    case (st_reg.wdt_sel)
      2'h0:    period = WDT_PER0;
      2'h1:    period = WDT_PER1;
      2'h2:    period = WDT_PER2;
      default: period = WDT_PER3;
    endcase
  end

  assign boot_target = BOOT_SLOW ? BOOT_SLOW_CYC : FAST_CYC;
  assign wake_target = st_reg.fast_wake ? FAST_CYC : WAKE_NORMAL;
  assign aphase      = hsel & htrans[1] & hready;

  // Threshold only watched once boot completes and outside the halt modes
  assign uv_active   = (st_reg.state == S_RUN || st_reg.state == S_WAKE) & ~st_reg.uv_dis;

  // Next-state logic for bus, watchdog and supervisor
  always_comb begin
    st_next         = st_reg;
    st_next.rc_prev = rc_s;
    st_next.wdt_rst = 1'b0;
    st_next.wr_pend = aphase & hwrite;
    if (aphase) begin
      st_next.waddr = haddr[7:0];
    end
    // Read data captured in the address phase
    if (aphase && !hwrite) begin
      if (haddr[7:0] == OFF_CTRL) begin
        st_next.rdata = {28'h000_0000, st_reg.wdt_en, st_reg.uv_dis, st_reg.wdt_sel};
      end else if (haddr[7:0] == OFF_CLKMODE) begin
        st_next.rdata = {31'h0000_0000, st_reg.rc_en};
      end else if (haddr[7:0] == OFF_STATUS) begin
        st_next.rdata = {29'h0000_0000, st_reg.state == S_RUN, uv_active, st_reg.wdt_en};
      end else if (haddr[7:0] == OFF_WDT_COUNT) begin
        st_next.rdata = {13'h0000, st_reg.wdt_cnt};
      end else begin
        st_next.rdata = 32'h0000_0000;
      end
    end
    // Writes land at the end of the data phase; CPU cannot write during boot
    if (st_reg.wr_pend && st_reg.state != S_BOOT) begin
      if (st_reg.waddr == OFF_CTRL) begin
        st_next.wdt_sel = hwdata[CTRL_SEL_LSB +: 2];
        st_next.uv_dis  = hwdata[CTRL_UV_DIS];
        st_next.wdt_en  = hwdata[CTRL_WDT_EN];
      end else if (st_reg.waddr == OFF_CLKMODE) begin
        // Clock must already be switched away before this bit drops
        st_next.rc_en = hwdata[CLK_RC_EN];
      end
    end
    // Calibration wins over a same-cycle enable write
    if (clock_calibration_routine && st_reg.state != S_BOOT) begin
      st_next.wdt_en = 1'b0;
    end
    // Watchdog counter
    if (!st_reg.wdt_en) begin
      st_next.wdt_cnt = 19'h0_0000;
    end else if (wdt_clear) begin
      st_next.wdt_cnt = 19'h0_0000;
    end else if (tick) begin
      if (st_reg.wdt_cnt == period - 19'h0_0001) begin
        st_next.wdt_cnt = 19'h0_0000;
        st_next.wdt_rst = 1'b1;
      end else begin
        st_next.wdt_cnt = st_reg.wdt_cnt + 19'h0_0001;
      end
    end
    // Boot, halt and wake sequencing
    case (st_reg.state)
      S_BOOT: begin
        if (tick) begin
          if (st_reg.dly_cnt == boot_target - 12'h001) begin
            st_next.state   = S_RUN;
            st_next.dly_cnt = 12'h000;
          end else begin
            st_next.dly_cnt = st_reg.dly_cnt + 12'h001;
          end
        end
      end
      S_RUN: begin
        if (standby_halt_req || powerdown_halt_req) begin
          st_next.state = S_HALT;
        end
      end
      S_HALT: begin
        if (wake_event) begin
          st_next.state     = S_WAKE;
          st_next.dly_cnt   = 12'h000;
          st_next.fast_wake = fast_wake_sel;
        end
      end
      S_WAKE: begin
        if (tick) begin
          if (st_reg.dly_cnt == wake_target - 12'h001) begin
            st_next.state   = S_RUN;
            st_next.dly_cnt = 12'h000;
          end else begin
            st_next.dly_cnt = st_reg.dly_cnt + 12'h001;
          end
        end
      end
      default: begin
        st_next.state = S_BOOT;
      end
    endcase
  end

  // Watchdog enabled straight out of reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg         <= '0;
      st_reg.state   <= S_BOOT;
      st_reg.wdt_en  <= RST_WDT_EN;
      st_reg.rc_en   <= RST_RC_EN;
      st_reg.uv_dis  <= RST_UV_DIS;
      st_reg.wdt_sel <= RST_WDT_SEL;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = st_reg.rdata;
  assign wdt_reset         = st_reg.wdt_rst;
  assign low_voltage_reset = uv_active & lv_s;
  assign uv_threshold_sel  = UV_LEVEL;
  assign cpu_run           = st_reg.state == S_RUN;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_boot_wdt_on;
    st_reg.state == S_BOOT |-> st_reg.wdt_en;
  endproperty
  a_boot_wdt_on: assert property (p_boot_wdt_on) else $error("watchdog off during boot");

  property p_cal_off;
    clock_calibration_routine && st_reg.state != S_BOOT |=>
      !st_reg.wdt_en ##1 (!st_reg.wdt_en || $past(st_reg.wr_pend));
  endproperty
  a_cal_off: assert property (p_cal_off) else $error("calibration left watchdog on");
  property p_rc_off_hold;
    !st_reg.rc_en && !wdt_clear && st_reg.wdt_en |=> $stable(st_reg.wdt_cnt) || !$past(st_reg.wdt_en);
  endproperty
  a_rc_off_hold: assert property (p_rc_off_hold) else $error("watchdog counted with oscillator off");

  property p_timeout;
    st_reg.wdt_en && tick && !wdt_clear && st_reg.wdt_cnt == period - 19'h0_0001 |=>
      wdt_reset && st_reg.wdt_cnt == 19'h0_0000;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no reset at selected period");
  property p_no_early;
    wdt_reset |-> $past(st_reg.wdt_cnt) == $past(period) - 19'h0_0001;
  endproperty
  a_no_early: assert property (p_no_early) else $error("watchdog reset at wrong count");

  property p_clear;
    wdt_clear |=> st_reg.wdt_cnt == 19'h0_0000 && !wdt_reset;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not restart count");

  property p_level;
    uv_threshold_sel == UV_LEVEL;
  endproperty
  a_level: assert property (p_level) else $error("threshold level changed");

  property p_uv_boot;
    st_reg.state == S_BOOT |-> !low_voltage_reset;
  endproperty
  a_uv_boot: assert property (p_uv_boot) else $error("low-voltage reset before power-on done");

  property p_uv_dis;
    st_reg.uv_dis |-> !low_voltage_reset;
  endproperty
  a_uv_dis: assert property (p_uv_dis) else $error("low-voltage reset while disabled");

  property p_uv_halt;
    st_reg.state == S_HALT |-> !low_voltage_reset;
  endproperty
  a_uv_halt: assert property (p_uv_halt) else $error("low-voltage reset in halt");

  property p_fast_wake;
    st_reg.state == S_WAKE && st_reg.fast_wake && tick && st_reg.dly_cnt == FAST_CYC - 12'h001 |=> cpu_run;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("fast wake not after 45 cycles");

  property p_boot_len;
    st_reg.state == S_BOOT ##1 st_reg.state == S_RUN |-> $past(st_reg.dly_cnt) == boot_target - 12'h001;
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("boot delay wrong length");

  c_timeout:   cover property (wdt_reset);
  c_fast_wake: cover property (st_reg.state == S_WAKE && st_reg.fast_wake ##1 cpu_run);
  c_uv:        cover property (low_voltage_reset);
  c_cal:       cover property (clock_calibration_routine && st_reg.wdt_en);
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the watchdog and low-voltage reset supervisor
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import wdt_uv_pkg::*;
  // Shortened periods keep the run brief; expectations follow these values
  localparam logic [18:0] PER [4] = '{19'h0_0010, 19'h0_0020, 19'h0_0040, 19'h0_0080};
  localparam int          WAKE_N  = 10;
  localparam int          RC_DIV  = 8;
  localparam int          TOL     = 24;

  logic        clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hready;
  wire         hresp;
  wire  [31:0] hrdata;
  logic        low_speed_rc_osc;
  logic        low_voltage_detect;
  logic [4:0]  pls;
  logic        fast_wake_sel;
  wire         wdt_reset;
  wire         low_voltage_reset;
  wire  [2:0]  uv_threshold_sel;
  wire         cpu_run;
  logic        rc_on;
  logic [2:0]  rc_div;
  int          failures;
  int          n_tests;
  int          cyc;
  logic [31:0] rd;

  wdt_uv_supervisor #(.UV_LEVEL(3'h3), .BOOT_SLOW(1'b0), .WDT_PER0(PER[0]), .WDT_PER1(PER[1]),
                       .WDT_PER2(PER[2]), .WDT_PER3(PER[3]), .WAKE_NORMAL(12'h00A)) i_dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .low_speed_rc_osc(low_speed_rc_osc), .low_voltage_detect(low_voltage_detect),
    .wdt_clear(pls[0]), .clock_calibration_routine(pls[1]), .standby_halt_req(pls[2]),
    .powerdown_halt_req(pls[3]), .wake_event(pls[4]), .fast_wake_sel(fast_wake_sel),
    .wdt_reset(wdt_reset), .low_voltage_reset(low_voltage_reset),
    .uv_threshold_sel(uv_threshold_sel), .cpu_run(cpu_run)
  );

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Slow oscillator, one tick every eight clocks; held low when switched off
  always @(posedge clk) begin
    rc_div <= rc_div + 3'd1;
    low_speed_rc_osc <= rc_on & rc_div[2];
  end

  task automatic stop_test;
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded waits end the run through the same closing report
  task automatic timed_out;
    check(32'h0, 32'h1);
    stop_test();
  endtask

  // One AHB-Lite single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    hsize <= 3'h2;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) timed_out();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) timed_out();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // One-cycle strobe on a control input
  task automatic pulse(input int i);
    @(posedge clk);
    pls[i] <= 1'b1;
    @(posedge clk);
    pls <= 5'h0;
  endtask

  // Cycles until cpu_run rises, or until the watchdog fires
  task automatic wait_for(input logic wdt, output int c);
    c = 0;
    // Look first at the next settled half cycle, never at a pulse launched before the call
    do begin
      @(negedge clk);
      c++;
    end while ((wdt ? wdt_reset : cpu_run) !== 1'b1 && c < 5000);
    if (c >= 5000) timed_out();
  endtask

  // Counts watchdog pulses over a stretch of cycles
  task automatic quiet(input int n, output int p);
    p = 0;
    repeat (n) begin
      @(negedge clk);
      if (wdt_reset !== 1'b0) p++;
    end
  endtask

  task automatic near(input int c, input int exp);
    check({31'h0, (c + TOL >= exp) && (c <= exp + TOL)}, 32'h1);
  endtask

  initial begin
    failures = 0;
    n_tests = 0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pls = 5'h0;
    fast_wake_sel = 1'b0;
    low_voltage_detect = 1'b1;
    rc_on = 1'b1;
    rc_div = 3'h0;
    low_speed_rc_osc = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    check(uv_threshold_sel, 32'h3);
    repeat (100) @(negedge clk);
    // Supply is low throughout boot, yet no reset may be raised yet
    check(low_voltage_reset, 1'b0);
    wait_for(1'b0, cyc);
    near(cyc + 100, 45 * RC_DIV);
    repeat (8) @(negedge clk);
    check(low_voltage_reset, 1'b1);
    bus(1'b0, OFF_CTRL, 32'h0, rd);
    check(rd, 32'h0000_0008);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd & 32'h0000_0007, 32'h0000_0007);
    // Disable bit drops the reset, clearing it restores it
    wr(OFF_CTRL, 32'h0000_000C);
    check(hresp, 32'h0);
    repeat (8) @(negedge clk);
    check(low_voltage_reset, 1'b0);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd & 32'h0000_0002, 32'h0);
    wr(OFF_CTRL, 32'h0000_0008);
    repeat (8) @(negedge clk);
    check(low_voltage_reset, 1'b1);
    // Every period select, timed from a clear
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CTRL, 32'h0000_0008 | s);
      pulse(0);
      wait_for(1'b1, cyc);
      near(cyc, int'(PER[s]) * RC_DIV);
    end
    // Calibration switches the watchdog off until it is enabled again
    wr(OFF_CTRL, 32'h0000_0008);
    pulse(1);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd & 32'h1, 32'h0);
    quiet(400, cyc);
    check(cyc, 32'h0);
    wr(OFF_CTRL, 32'h0000_0008);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd & 32'h1, 32'h1);
    // Oscillator switched off in its own write; pin still toggles, so only the enable gate holds the count
    wr(OFF_CLKMODE, 32'h0);
    bus(1'b0, OFF_CLKMODE, 32'h0, rd);
    check(rd, 32'h0);
    pulse(0);
    quiet(400, cyc);
    check(cyc, 32'h0);
    rc_on <= 1'b0;
    bus(1'b0, OFF_WDT_COUNT, 32'h0, rd);
    check(rd, 32'h0);
    rc_on <= 1'b1;
    wr(OFF_CLKMODE, 32'h1);
    // Both halt modes with supply low; fast and normal wake delays
    for (int m = 0; m < 2; m++) begin
      pulse(2 + m);
      repeat (8) @(negedge clk);
      check(cpu_run, 1'b0);
      check(low_voltage_reset, 1'b0);
      fast_wake_sel <= (m == 0);
      pulse(4);
      wait_for(1'b0, cyc);
      near(cyc, (m == 0 ? 45 : WAKE_N) * RC_DIV);
    end
    stop_test();
  end
endmodule
`default_nettype wire
